// ===== hdl/pcmt_pkg.sv
package pcmt_pkg;

  // Coprocessor register number and selects of the four registers.
  localparam logic [4:0] REG_NUM          = 5'h01;
  localparam logic [2:0] SEL_CTX_COUNTS   = 3'h3;
  localparam logic [2:0] SEL_YQ_MASK      = 3'h4;
  localparam logic [2:0] SEL_SCHED_HINT   = 3'h5;
  localparam logic [2:0] SEL_SCHED_FBACK  = 3'h6;

  // Field positions of the context-resource register.
  localparam int UDI_LSB  = 20;
  localparam int UDI_MSB  = 27;
  localparam int CP2_LSB  = 10;
  localparam int CP2_MSB  = 17;
  localparam int CP1_LSB  = 0;
  localparam int CP1_MSB  = 7;
  localparam logic [31:0] CTX_WRITABLE = 32'h0FF3FCFF;

  // Yield-qualifier mask layout.
  localparam int YQ_BITS = 31;
  localparam logic [31:0] YQ_RESET = 32'h00000000;

  // Scheduler registers and exception cause.
  localparam logic [31:0] SCHED_HINT_RESET  = 32'h00000000;
  localparam logic [31:0] SCHED_FBACK_RESET = 32'h00000000;
  localparam logic [31:0] FBACK_STEP        = 32'h00000001;
  localparam logic [2:0]  CAUSE_BAD_QUAL    = 3'h3;

  // Coprocessor register access request.
  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [4:0] num;
    logic [2:0] sel;
    logic [31:0] wdata;
  } pcmt_req_t;

  // Yield instruction check request.
  typedef struct packed
  {
    logic        valid;
    logic [31:0] qual;
  } pcmt_yield_t;

  typedef enum logic [1:0]
  {
    PCMT_IDLE = 2'b00,
    PCMT_DONE = 2'b01
  } pcmt_state_t;

endpackage

// ===== hdl/pcmt_regs.sv
`timescale 1ns/1ps
`default_nettype none
module pcmt_regs
#(
  parameter int          QUAL_INPUTS = 31,
  parameter logic [7:0]  UDI_PRESET  = 8'h00,
  parameter logic [7:0]  CP2_PRESET  = 8'h00,
  parameter logic [7:0]  CP1_PRESET  = 8'h01
)
(
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Register access from this or a master virtual processor.
  input  wire pcmt_pkg::pcmt_req_t  req,
  input  wire logic                 req_cross,
  input  wire logic                 master_processor_flag,
  input  wire logic                 processor_config_enable,
  output logic [31:0]               rdata,
  output logic                      rvalid,
  output logic                      req_refused,
  // Yield qualifier check.
  input  wire pcmt_pkg::pcmt_yield_t yield_in,
  output logic                      thread_exception,
  output logic [2:0]                thread_exception_cause,
  // Scheduler side.
  input  wire logic                 instr_retired,
  output logic [31:0]               scheduler_hint_out,
  output logic [31:0]               share_grant
);

  // Elaboration checks. The mask logic serves 1 to 31 qualifier inputs,
  // and each context field must be exactly as wide as its 8-bit preset.
  if (QUAL_INPUTS < 1)
  begin : g_qual_low
    $error("QUAL_INPUTS below one");
  end

  if (QUAL_INPUTS > pcmt_pkg::YQ_BITS)
  begin : g_qual_high
    $error("QUAL_INPUTS above the mask width");
  end

  if (pcmt_pkg::UDI_MSB - pcmt_pkg::UDI_LSB != 7)
  begin : g_udi_width
    $error("USER_DEFINED_INSTRUCTION field width does not match its preset");
  end

  if (pcmt_pkg::CP2_MSB - pcmt_pkg::CP2_LSB != 7)
  begin : g_cp2_width
    $error("CP2 field width does not match its preset");
  end

  if (pcmt_pkg::CP1_MSB - pcmt_pkg::CP1_LSB != 7)
  begin : g_cp1_width
    $error("CP1 field width does not match its preset");
  end

  //////////////////////////////////////////////////////////////////////////

  logic [31:0] context_resource_counts;
  logic [31:0] yield_qualifier_mask;
  logic [31:0] scheduler_hint;
  logic [31:0] scheduler_feedback;
  wire  [31:0] qual_impl;
  wire  [31:0] ctx_preset;

  // Implemented qualifier bits; bit 31 and missing inputs stay zero.
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++)
    begin : g_qual
      assign qual_impl[gi] = (gi < QUAL_INPUTS) ? 1'b1 : 1'b0;
    end
  endgenerate

  // Context-resource preset, placed bit by bit from the field positions;
  // every bit outside the three count fields is reserved and stays zero.
  genvar gc;
  generate
    for (gc = 0; gc < 32; gc++)
    begin : g_ctx
      if (gc >= pcmt_pkg::UDI_LSB && gc <= pcmt_pkg::UDI_MSB)
      begin : g_udi
        assign ctx_preset[gc] = UDI_PRESET[gc - pcmt_pkg::UDI_LSB];
      end
      else if (gc >= pcmt_pkg::CP2_LSB && gc <= pcmt_pkg::CP2_MSB)
      begin : g_cp2
        assign ctx_preset[gc] = CP2_PRESET[gc - pcmt_pkg::CP2_LSB];
      end
      else if (gc >= pcmt_pkg::CP1_LSB && gc <= pcmt_pkg::CP1_MSB)
      begin : g_cp1
        assign ctx_preset[gc] = CP1_PRESET[gc - pcmt_pkg::CP1_LSB];
      end
      else
      begin : g_rsvd
        assign ctx_preset[gc] = 1'b0;
      end
    end
  endgenerate


  // A cross-context access needs the master flag.
  wire allowed  = !req_cross || master_processor_flag;
  wire hit      = req.num == pcmt_pkg::REG_NUM;
  wire wr_ok    = req.wr && hit && allowed;
  wire wr_ctx   = wr_ok && req.sel == pcmt_pkg::SEL_CTX_COUNTS;
  wire wr_yq    = wr_ok && req.sel == pcmt_pkg::SEL_YQ_MASK;
  wire wr_hint  = wr_ok && req.sel == pcmt_pkg::SEL_SCHED_HINT;
  wire wr_fback = wr_ok && req.sel == pcmt_pkg::SEL_SCHED_FBACK;
  wire ctx_wen  = wr_ctx && processor_config_enable;


  // Reserved bits are cleared on the way in, so a careless write can
  // never make them read back as one.
  wire [31:0] next_ctx   = req.wdata & pcmt_pkg::CTX_WRITABLE;
  wire [31:0] next_yq    = req.wdata & qual_impl;

  // Software clear wins over a same-cycle retirement, since the clear
  // defines the start of a new counting interval.
  wire [31:0] next_fback = wr_fback ? req.wdata :
                           scheduler_feedback +
                           (instr_retired ? pcmt_pkg::FBACK_STEP
                                          : 32'h00000000);


  // Read selection: one select line per register, so an unused select
  // reads zero instead of aliasing a neighbour.
  wire rd_sel_ctx   = req.sel == pcmt_pkg::SEL_CTX_COUNTS;
  wire rd_sel_yq    = req.sel == pcmt_pkg::SEL_YQ_MASK;
  wire rd_sel_hint  = req.sel == pcmt_pkg::SEL_SCHED_HINT;
  wire rd_sel_fback = req.sel == pcmt_pkg::SEL_SCHED_FBACK;
  wire rd_ok        = req.rd && hit && allowed;
  wire refuse       = (req.rd || req.wr) && hit && !allowed;

  wire [31:0] sel_rdata =
    ({32{rd_sel_ctx}}   & context_resource_counts) |
    ({32{rd_sel_yq}}    & yield_qualifier_mask) |
    ({32{rd_sel_hint}}  & scheduler_hint) |
    ({32{rd_sel_fback}} & scheduler_feedback);
  wire [31:0] next_rdata = rd_ok ? sel_rdata : 32'h00000000;

  // Yield check: positive qualifier with a bit outside the mask.
  wire qual_pos = !yield_in.qual[31];
  wire qual_bad = |(yield_in.qual & ~yield_qualifier_mask);
  wire yield_fault = yield_in.valid && qual_pos && qual_bad;

  // The cause holds its last value between faults, so software can read
  // it after the one-cycle exception pulse has gone.
  wire [2:0] next_cause = yield_fault ? pcmt_pkg::CAUSE_BAD_QUAL
                                      : thread_exception_cause;

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      context_resource_counts <= ctx_preset;
    end
    else if (ctx_wen)
    begin
      context_resource_counts <= next_ctx;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      yield_qualifier_mask <= pcmt_pkg::YQ_RESET;
    end
    else if (wr_yq)
    begin
      yield_qualifier_mask <= next_yq;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scheduler_hint <= pcmt_pkg::SCHED_HINT_RESET;
    end
    else if (wr_hint)
    begin
      scheduler_hint <= req.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scheduler_feedback <= pcmt_pkg::SCHED_FBACK_RESET;
    end
    else
    begin
      scheduler_feedback <= next_fback;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdata       <= 32'h00000000;
      rvalid      <= 1'b0;
      req_refused <= 1'b0;
    end
    else
    begin
      rvalid      <= rd_ok;
      rdata       <= next_rdata;
      req_refused <= refuse;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      thread_exception       <= 1'b0;
      thread_exception_cause <= 3'h0;
    end
    else
    begin
      thread_exception       <= yield_fault;
      thread_exception_cause <= next_cause;
    end
  end

  // The hint is passed to the core scheduler, which divides total issue
  // bandwidth among virtual processors; thread schedule values only split
  // the share granted here. share_grant copies the hint, so a zero hint grants a zero share.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scheduler_hint_out <= 32'h00000000;
      share_grant        <= 32'h00000000;
    end
    else
    begin
      scheduler_hint_out <= scheduler_hint;
      share_grant        <= scheduler_hint;
    end
  end

endmodule
`default_nettype wire

// ===== bench/pcmt_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module pcmt_regs_props
(
  // Clock and reset.
  input wire logic                  clk,
  input wire logic                  rst_n,
  // Watched ports.
  input wire pcmt_pkg::pcmt_req_t   req,
  input wire logic                  req_cross,
  input wire logic                  master_processor_flag,
  input wire logic [31:0]           rdata,
  input wire logic                  rvalid,
  input wire logic                  req_refused,
  input wire pcmt_pkg::pcmt_yield_t yield_in,
  input wire logic                  thread_exception,
  input wire logic [2:0]            thread_exception_cause
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic hit = (req.rd | req.wr) & (req.num == pcmt_pkg::REG_NUM);
  wire logic bar = req_cross & ~master_processor_flag;
  wire logic rd  = hit & req.rd & ~bar;
  ////////////////////////////////////////////////////////////////////////
  chk_ctx_rsvd_zero: assert property (rd && req.sel == 3'h3 |=>
    rvalid && (rdata & ~pcmt_pkg::CTX_WRITABLE) == 32'h0)
    else $error("context reserved bits not zero");
  chk_mask_top_zero: assert property (rd && req.sel == 3'h4 |=>
    rvalid && !rdata[31]) else $error("mask bit 31 not zero");
  chk_cause_value: assert property (thread_exception |->
    thread_exception_cause == 3'h3) else $error("wrong cause");
  chk_neg_qual: assert property (yield_in.valid && yield_in.qual[31]
    |=> !thread_exception) else $error("negative qualifier faulted");
  chk_empty_qual: assert property (yield_in.valid &&
    yield_in.qual == 32'h0 |=> !thread_exception) else $error("zero fault");
  chk_exc_source: assert property (thread_exception |->
    $past(yield_in.valid)) else $error("fault without yield");
  chk_refuse_pulse: assert property (hit && bar |=> req_refused)
    else $error("cross access not refused");
  chk_refuse_cause: assert property (req_refused |-> $past(hit & bar))
    else $error("spurious refusal");
  cover property (hit && bar);
  cover property (thread_exception);
  cover property (hit && req.wr && req.sel == 3'h3);
endmodule
bind pcmt_regs pcmt_regs_props u_props (.clk, .rst_n, .req, .req_cross,
  .master_processor_flag, .rdata, .rvalid, .req_refused, .yield_in,
  .thread_exception, .thread_exception_cause);
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clk = 0;
  logic                  rst_n = 0;
  pcmt_pkg::pcmt_req_t   req = '0;
  logic                  req_cross = 0;
  logic                  master_processor_flag = 0;
  logic                  processor_config_enable = 0;
  pcmt_pkg::pcmt_yield_t yield_in = '0;
  logic                  instr_retired = 0;
  logic [31:0]           rdata, scheduler_hint_out, share_grant;
  logic                  rvalid, req_refused, thread_exception;
  logic [2:0]            thread_exception_cause;
  int                    err_total = 0, n_tests = 0, cyc = 0;
  pcmt_regs dut
  (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .req                     (req),
    .req_cross               (req_cross),
    .master_processor_flag   (master_processor_flag),
    .processor_config_enable (processor_config_enable),
    .rdata                   (rdata),
    .rvalid                  (rvalid),
    .req_refused             (req_refused),
    .yield_in                (yield_in),
    .thread_exception        (thread_exception),
    .thread_exception_cause  (thread_exception_cause),
    .instr_retired           (instr_retired),
    .scheduler_hint_out      (scheduler_hint_out),
    .share_grant             (share_grant)
  );
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Sampling at the falling edge keeps stimulus on rising edges only.
  task automatic acc(input logic w, input logic [2:0] s,
    input logic [31:0] d);
    @(posedge clk) req <= '{~w, w, pcmt_pkg::REG_NUM, s, d};
    @(posedge clk) req <= '0;
    @(negedge clk);
  endtask
  task automatic yq(input logic [31:0] q);
    @(posedge clk) yield_in <= '{1'b1, q};
    @(posedge clk) yield_in <= '0;
    @(negedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_ctx();
    acc(0, 3'h3, 32'h0);
    chk(rdata, 32'h00000001);
    acc(1, 3'h3, 32'hFFFFFFFF);
    acc(0, 3'h3, 32'h0);
    chk(rdata, 32'h00000001);
    @(posedge clk) processor_config_enable <= 1'b1;
    acc(1, 3'h3, 32'hFFFFFFFF);
    acc(0, 3'h3, 32'h0);
    chk(rdata, 32'h0FF3FCFF);
    $display("t_ctx done");
  endtask
  task automatic t_mask();
    acc(0, 3'h4, 32'h0);
    chk(rdata, 32'h00000000);
    chk({31'h0, rvalid}, 32'h1);
    acc(1, 3'h4, 32'hFFFFFFFF);
    acc(0, 3'h4, 32'h0);
    chk(rdata, 32'h7FFFFFFF);
    yq(32'h00000002);
    chk({31'h0, thread_exception}, 32'h0);
    acc(1, 3'h4, 32'h00000001);
    yq(32'h00000002);
    chk({31'h0, thread_exception}, 32'h1);
    chk({29'h0, thread_exception_cause}, 32'h3);
    yq(32'h80000002);
    chk({31'h0, thread_exception}, 32'h0);
    yq(32'h00000000);
    chk({31'h0, thread_exception}, 32'h0);
    chk({29'h0, thread_exception_cause}, 32'h3);
    $display("t_mask done");
  endtask
  task automatic t_sched();
    acc(0, 3'h5, 32'h0);
    chk(rdata, 32'h0);
    acc(1, 3'h5, 32'h00000005);
    acc(0, 3'h5, 32'h0);
    chk(rdata, 32'h00000005);
    chk(scheduler_hint_out, 32'h00000005);
    chk(share_grant, 32'h00000005);
    @(posedge clk) instr_retired <= 1'b1;
    repeat (3) @(posedge clk);
    instr_retired <= 1'b0;
    acc(0, 3'h6, 32'h0);
    chk(rdata, 32'h00000003);
    acc(1, 3'h6, 32'h0);
    acc(0, 3'h6, 32'h0);
    chk(rdata, 32'h0);
    $display("t_sched done");
  endtask
  task automatic t_cross();
    @(posedge clk) req_cross <= 1'b1;
    acc(1, 3'h5, 32'h00000009);
    chk({31'h0, req_refused}, 32'h1);
    acc(0, 3'h5, 32'h0);
    chk(rdata, 32'h00000000);
    @(posedge clk) master_processor_flag <= 1'b1;
    acc(1, 3'h5, 32'h00000009);
    acc(0, 3'h5, 32'h0);
    chk(rdata, 32'h00000009);
    $display("t_cross done");
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      test_done();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_ctx();
    t_mask();
    t_sched();
    t_cross();
    test_done();
  end
endmodule
`default_nettype wire
